// [hdl/flash_boot_pkg.sv]
package flash_boot_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_FLASH_CTRL = 8'h04;
  localparam logic [7:0] OFS_ERASE_BLK = 8'h08;
  localparam logic [7:0] OFS_OVERLAP = 8'h0c;
  localparam logic [7:0] OFS_BOOT_STAT = 8'h10;
  localparam logic [7:0] OFS_BOOT_COUNT = 8'h14;
  // field positions
  localparam int FC_PROG_BIT = 0;
  localparam int FC_ERASE_BIT = 1;
  localparam int OVL_SEL_BIT = 3;
  localparam int BS_PERIOD_LSB = 16;
  // reset values
  localparam logic [1:0] FLASH_CTRL_RST = 2'h0;
  localparam logic [11:0] ERASE_BLK_RST = 12'h000;
  localparam logic [3:0] OVERLAP_RST = 4'h0;
  localparam logic [3:0] OVERLAP_RSVD = 4'hf;
  // eight 4k blocks, one 32k block, three 64k blocks
  localparam int NUM_BLOCKS = 12;
  localparam int SMALL_BLOCK_SHIFT = 12;
  // lower mode pin pairs {mid, low}
  localparam logic [1:0] LOW_MODE5 = 2'h1;
  localparam logic [1:0] LOW_MODE7 = 2'h3;
  // addresses
  localparam logic [23:0] BRANCH_ADDR = 24'hffe720;
  localparam logic [23:0] OVL_RAM_BASE = 24'hffe000;
  // serial handshake bytes
  localparam logic [7:0] ACK_BYTE = 8'h00;
  localparam logic [7:0] CONFIRM_BYTE = 8'h55;
  // a zero byte is low for start plus eight data bits
  localparam logic [15:0] LOW_BITS_PER_ZERO = 16'h0009;
  // timing: one state is one clock
  localparam int CLK_HZ = 10_000_000;
  localparam int SETTLE_STATES = 100;
  localparam int SETTLE_CYC = SETTLE_STATES;
  localparam logic [1:0] CAPTURE_CYC = 2'h2;
  typedef enum logic [1:0] {
    OP_USER = 2'b00,
    OP_BOOT = 2'b01,
    OP_UPROG = 2'b10
  } op_mode_e;
  typedef enum logic [3:0] {
    B_OFF = 4'b0000, B_SETTLE = 4'b0001, B_IDLE = 4'b0010, B_MEASURE = 4'b0011,
    B_COUNT = 4'b0100, B_DIVIDE = 4'b0101, B_ACK = 4'b0110, B_ACKWAIT = 4'b0111,
    B_CONFIRM = 4'b1000, B_LENHI = 4'b1001, B_LENLO = 4'b1010, B_LOAD = 4'b1011,
    B_ERASE = 4'b1100, B_BRANCH = 4'b1101, B_DONE = 4'b1110, B_HALT = 4'b1111
  } boot_state_e;
endpackage

// [hdl/uart_link.sv]
`timescale 1ns/1ps
`default_nettype none
module uart_link (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // rate and line
  input wire logic [15:0] bitPeriod,
  input wire logic rxEnable,
  input wire logic rxd,
  output logic txd,
  // receive side
  output logic rxValid,
  output logic [7:0] rxData,
  // transmit side
  input wire logic txStart,
  input wire logic [7:0] txData,
  output logic txBusy
);
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10, RX_STOP = 2'b11
  } rx_state_e;
  rx_state_e rxState, next_rxState;
  logic [15:0] rxCnt, next_rxCnt;
  logic [2:0] rxBit, next_rxBit;
  logic [7:0] rxShift, next_rxShift;
  logic next_rxValid;
  logic [7:0] next_rxData;
  logic [9:0] txShift, next_txShift;
  logic [15:0] txCnt, next_txCnt;
  logic [3:0] txLeft, next_txLeft;

  // receiver: 8N1, sampled mid-bit; bad stop bit drops the byte
  always_comb begin
    next_rxState = rxState;
    next_rxCnt = rxCnt;
    next_rxBit = rxBit;
    next_rxShift = rxShift;
    next_rxValid = 1'b0;
    next_rxData = rxData;
    unique case (rxState)
      RX_IDLE: begin
        if (!rxd) begin
          next_rxState = RX_START;
          next_rxCnt = {1'b0, bitPeriod[15:1]};
        end
      end
      RX_START: begin
        if (rxCnt == 16'h0000) begin
          next_rxState = rxd ? RX_IDLE : RX_DATA; // glitch rejected
          next_rxCnt = bitPeriod - 16'h0001;
          next_rxBit = 3'h0;
        end else next_rxCnt = rxCnt - 16'h0001;
      end
      RX_DATA: begin
        if (rxCnt == 16'h0000) begin
          next_rxShift = {rxd, rxShift[7:1]};
          next_rxCnt = bitPeriod - 16'h0001;
          if (rxBit == 3'h7) next_rxState = RX_STOP;
          next_rxBit = rxBit + 3'h1;
        end else next_rxCnt = rxCnt - 16'h0001;
      end
      RX_STOP: begin
        if (rxCnt == 16'h0000) begin
          next_rxState = RX_IDLE;
          next_rxValid = rxd;
          if (rxd) next_rxData = rxShift;
        end else next_rxCnt = rxCnt - 16'h0001;
      end
    endcase
    if (!rxEnable) next_rxState = RX_IDLE;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rxState <= RX_IDLE;
      rxCnt <= 16'h0000;
      rxBit <= 3'h0;
      rxShift <= 8'h00;
      rxValid <= 1'b0;
      rxData <= 8'h00;
    end else begin
      rxState <= next_rxState;
      rxCnt <= next_rxCnt;
      rxBit <= next_rxBit;
      rxShift <= next_rxShift;
      rxValid <= next_rxValid;
      rxData <= next_rxData;
    end
  end

  // transmitter: 8N1, lsb first, idle high
  always_comb begin
    next_txShift = txShift;
    next_txCnt = txCnt;
    next_txLeft = txLeft;
    if (txLeft == 4'h0) begin
      if (txStart) begin
        next_txShift = {1'b1, txData, 1'b0};
        next_txLeft = 4'ha;
        next_txCnt = bitPeriod - 16'h0001;
      end
    end else if (txCnt == 16'h0000) begin
      next_txShift = {1'b1, txShift[9:1]};
      next_txLeft = txLeft - 4'h1;
      next_txCnt = bitPeriod - 16'h0001;
    end else next_txCnt = txCnt - 16'h0001;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      txShift <= 10'h3ff;
      txCnt <= 16'h0000;
      txLeft <= 4'h0;
    end else begin
      txShift <= next_txShift;
      txCnt <= next_txCnt;
      txLeft <= next_txLeft;
    end
  end

  assign txd = txShift[0];
  assign txBusy = (txLeft != 4'h0);
endmodule // uart_link
`default_nettype wire

// [hdl/flash_boot_mode_loader.sv]
// Behaviour
// (R1) mode taken from mode pins and write-enable pin latched at reset release
// (R2) user mode reads flash but blocks program and erase
// (R3) program and erase only in boot, user program or PROM mode
// (R4) mode 6 never enters boot or user program mode
// (R5) software clears flash control bits and waits before toggling write enable
// (R6) boot erases the whole array to all-ones before programming
// (R7) user program mode erases whole blocks only, never bytes
// (R8) twelve blocks: three 64k, one 32k, eight 4k, each erasable
// (R9) emulation reads of the chosen block return overlap RAM
// (R10) clearing overlap select returns the block to real flash
// (R11) software runs emulation only in user or user program mode
// (R12) software keeps loaded programs out of the overlap RAM
// (R13) write enable 1, lower pins 01 or 11; upper 0 boot, 1 user program
// (R14) boot mode shows inverted upper pin and lower pins in mode select bits
// (R15) boot stores serial bytes in RAM program area, then branches to ffe720
// (R16) boot measures low period of host zero bytes to find bit rate
// (R17) host frames are 8 data bits, 1 stop bit, no parity
// (R18) after rate found, loader sends one zero byte
// (R19) host answers with 55, or resets and retries
// (R20) host uses 4800, 9600 or 19200 bps only
// (R21) rate adjustment holds only in the listed clock ranges
// (R22) loader RAM area locked during boot, freed once program runs
// (R23) wait about 100 states after reset before measuring receive line
// (R24) a wrong confirm byte halts the loader until reset
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module flash_boot_mode_loader #(
  parameter int LEN_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // mode pins
  input wire logic modePinHigh,
  input wire logic modePinMid,
  input wire logic modePinLow,
  input wire logic flashWriteEnablePin,
  // serial channel 1
  input wire logic rxdPin,
  output logic txdPin,
  // flash read path
  input wire logic [23:0] flashRdAddr,
  output logic ovlHit,
  output logic [23:0] ovlRamAddr,
  // program and erase permission
  output logic programEnable,
  output logic [flash_boot_pkg::NUM_BLOCKS-1:0] eraseBlockEnable,
  output logic eraseAllReq,
  input wire logic eraseAllDone,
  // loader RAM writes and cpu hand-off
  output logic ramWrEn,
  output logic [23:0] ramWrAddr,
  output logic [7:0] ramWrData,
  output logic loaderAreaLock,
  output logic branchReq,
  output logic [23:0] branchAddr,
  output logic [1:0] opMode
);
  import flash_boot_pkg::*;

  logic [4:0] pinSync1, pinSync2;
  logic modeHighS, modeMidS, modeLowS, fweS, rxdS;
  logic [1:0] capCnt, next_capCnt;
  logic captured, next_captured;
  op_mode_e mode, next_mode;
  logic [2:0] modeSelect, next_modeSelect;
  boot_state_e bootState, next_bootState;
  logic [15:0] cnt, next_cnt;
  logic [15:0] quot, next_quot;
  logic [15:0] bitPeriod, next_bitPeriod;
  logic [LEN_W-1:0] loadLen, next_loadLen;
  logic [LEN_W-1:0] loadIdx, next_loadIdx;
  logic next_ramWrEn;
  logic [23:0] next_ramWrAddr;
  logic [7:0] next_ramWrData;
  logic txStart, txBusy, rxValid;
  logic [7:0] rxData;
  logic [1:0] flashCtrl, next_flashCtrl;
  logic [11:0] eraseBlk, next_eraseBlk;
  logic [3:0] ovlCtrl, next_ovlCtrl;
  logic [31:0] next_prdata;
  logic next_ovlHit, next_programEnable;
  logic [23:0] next_ovlRamAddr;
  logic [11:0] next_eraseBlockEnable;
  logic onBoard, loaderBusy, wrAccess, mapped;

  // pins come from outside: two flops before any use
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pinSync1 <= 5'h10;
      pinSync2 <= 5'h10;
    end else begin
      pinSync1 <= {rxdPin, flashWriteEnablePin, modePinHigh, modePinMid, modePinLow};
      pinSync2 <= pinSync1;
    end
  end
  assign {rxdS, fweS, modeHighS, modeMidS, modeLowS} = pinSync2;

  // latch the mode once the synchroniser has filled after release
  always_comb begin
    next_capCnt = capCnt;
    next_captured = captured;
    next_mode = mode;
    next_modeSelect = modeSelect;
    if (!captured) begin
      next_capCnt = capCnt + 2'h1;
      if (capCnt == CAPTURE_CYC) begin // (R1)
        next_captured = 1'b1;
        next_mode = OP_USER; // (R2) (R4)
        next_modeSelect = {modeHighS, modeMidS, modeLowS};
        // mode 6 (lower pins 10) falls through to user mode
        if (fweS && ({modeMidS, modeLowS} == LOW_MODE5 ||
            {modeMidS, modeLowS} == LOW_MODE7)) begin // (R13)
          next_mode = modeHighS ? OP_UPROG : OP_BOOT;
          if (!modeHighS) next_modeSelect = {~modeHighS, modeMidS, modeLowS}; // (R14)
        end
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      capCnt <= 2'h0;
      captured <= 1'b0;
      mode <= OP_USER;
      modeSelect <= 3'h0;
    end else begin
      capCnt <= next_capCnt;
      captured <= next_captured;
      mode <= next_mode;
      modeSelect <= next_modeSelect;
    end
  end

  assign onBoard = (mode != OP_USER); // (R3)
  assign loaderBusy = (bootState != B_OFF) && (bootState != B_DONE);

  // boot loader sequence
  always_comb begin
    next_bootState = bootState;
    next_cnt = cnt;
    next_quot = quot;
    next_bitPeriod = bitPeriod;
    next_loadLen = loadLen;
    next_loadIdx = loadIdx;
    next_ramWrEn = 1'b0;
    next_ramWrAddr = ramWrAddr;
    next_ramWrData = ramWrData;
    unique case (bootState)
      B_OFF: begin
        if (captured && mode == OP_BOOT) begin
          next_bootState = B_SETTLE;
          next_cnt = 16'(SETTLE_CYC - 1);
        end
      end
      B_SETTLE: begin
        if (cnt == 16'h0000) next_bootState = B_IDLE; // (R23)
        else next_cnt = cnt - 16'h0001;
      end
      // a falling edge only counts after the line was seen idle
      B_IDLE: if (rxdS) next_bootState = B_MEASURE;
      B_MEASURE: begin
        if (!rxdS) begin
          next_bootState = B_COUNT;
          next_cnt = 16'h0001;
        end
      end
      B_COUNT: begin
        if (rxdS) begin
          next_bootState = B_DIVIDE; // (R16)
          next_quot = 16'h0000;
        end else if (cnt != 16'hffff) next_cnt = cnt + 16'h0001;
      end
      // slow divide by nine: plenty of time before the next frame
      B_DIVIDE: begin
        if (cnt >= LOW_BITS_PER_ZERO) begin
          next_cnt = cnt - LOW_BITS_PER_ZERO;
          next_quot = quot + 16'h0001;
        end else if (quot < 16'h0002) next_bootState = B_HALT; // (R21)
        else begin
          next_bitPeriod = quot;
          next_bootState = B_ACK;
        end
      end
      B_ACK: next_bootState = B_ACKWAIT; // (R18)
      B_ACKWAIT: if (!txBusy) next_bootState = B_CONFIRM;
      B_CONFIRM: begin
        if (rxValid && rxData != ACK_BYTE) begin
          // leftover zero bytes are skipped
          next_bootState = (rxData == CONFIRM_BYTE) ? B_LENHI : B_HALT; // (R24)
        end
      end
      B_LENHI: begin
        if (rxValid) begin
          next_loadLen = {rxData, loadLen[7:0]};
          next_bootState = B_LENLO;
        end
      end
      B_LENLO: begin
        if (rxValid) begin
          next_loadLen = {loadLen[15:8], rxData};
          next_loadIdx = '0;
          next_bootState = ({loadLen[15:8], rxData} == 16'h0000) ? B_ERASE : B_LOAD;
        end
      end
      B_LOAD: begin
        if (rxValid) begin
          next_ramWrEn = 1'b1; // (R15)
          next_ramWrAddr = BRANCH_ADDR + 24'(loadIdx);
          next_ramWrData = rxData;
          next_loadIdx = loadIdx + 1'b1;
          if (loadIdx + 1'b1 == loadLen) next_bootState = B_ERASE;
        end
      end
      B_ERASE: if (eraseAllDone) next_bootState = B_BRANCH; // (R6)
      B_BRANCH: next_bootState = B_DONE;
      B_DONE: next_bootState = B_DONE;
      B_HALT: next_bootState = B_HALT; // (R24)
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bootState <= B_OFF;
      cnt <= 16'h0000;
      quot <= 16'h0000;
      bitPeriod <= 16'h0000;
      loadLen <= '0;
      loadIdx <= '0;
      ramWrEn <= 1'b0;
      ramWrAddr <= 24'h000000;
      ramWrData <= 8'h00;
    end else begin
      bootState <= next_bootState;
      cnt <= next_cnt;
      quot <= next_quot;
      bitPeriod <= next_bitPeriod;
      loadLen <= next_loadLen;
      loadIdx <= next_loadIdx;
      ramWrEn <= next_ramWrEn;
      ramWrAddr <= next_ramWrAddr;
      ramWrData <= next_ramWrData;
    end
  end

  assign txStart = (bootState == B_ACK);
  assign eraseAllReq = (bootState == B_ERASE); // (R6)
  assign branchReq = (bootState == B_BRANCH); // (R15)
  assign branchAddr = BRANCH_ADDR;
  assign loaderAreaLock = loaderBusy; // (R22)
  assign opMode = mode;

  // serial channel 1, receiver only listens once the rate is known
  uart_link u_link (
    .clk(clk),
    .resetn(resetn),
    .bitPeriod(bitPeriod),
    .rxEnable(bootState >= B_ACKWAIT),
    .rxd(rxdS),
    .txd(txdPin),
    .rxValid(rxValid),
    .rxData(rxData),
    .txStart(txStart),
    .txData(ACK_BYTE),
    .txBusy(txBusy)
  );

  // apb: zero wait state, read data captured in the setup cycle
  assign wrAccess = psel && penable && pwrite;
  always_comb begin
    mapped = 1'b1;
    next_prdata = prdata;
    next_flashCtrl = flashCtrl;
    next_eraseBlk = eraseBlk;
    next_ovlCtrl = ovlCtrl;
    unique case (paddr)
      OFS_MODE, OFS_FLASH_CTRL, OFS_ERASE_BLK, OFS_OVERLAP, OFS_BOOT_STAT, OFS_BOOT_COUNT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
    if (psel && !penable) begin
      next_prdata = 32'h00000000;
      unique case (paddr)
        OFS_MODE: next_prdata = {25'h0, fweS, onBoard, mode, modeSelect}; // (R14)
        OFS_FLASH_CTRL: next_prdata = {30'h0, flashCtrl};
        OFS_ERASE_BLK: next_prdata = {20'h0, eraseBlk};
        OFS_OVERLAP: next_prdata = {24'h0, OVERLAP_RSVD, ovlCtrl};
        OFS_BOOT_STAT: next_prdata = {bitPeriod, 12'h0, bootState};
        OFS_BOOT_COUNT: next_prdata = 32'(loadIdx);
        default: next_prdata = 32'h00000000;
      endcase
    end
    if (wrAccess && onBoard && paddr == OFS_FLASH_CTRL) next_flashCtrl = pwdata[1:0]; // (R2)
    if (wrAccess && onBoard && paddr == OFS_ERASE_BLK) next_eraseBlk = pwdata[11:0];
    if (wrAccess && paddr == OFS_OVERLAP) next_ovlCtrl = pwdata[3:0]; // (R10)
    // dropping write enable wipes the program and erase setup
    if (!fweS || !onBoard) begin
      next_flashCtrl = FLASH_CTRL_RST; // (R5)
      next_eraseBlk = ERASE_BLK_RST;
    end
  end

  // permission and overlap outputs, registered for clean timing
  always_comb begin
    next_programEnable = onBoard && fweS && !ovlCtrl[OVL_SEL_BIT] && !loaderBusy &&
      flashCtrl[FC_PROG_BIT]; // (R2) (R3)
    next_eraseBlockEnable = 12'h000;
    // only a single block at a time; byte erase does not exist
    if (next_programEnable || (onBoard && fweS && !ovlCtrl[OVL_SEL_BIT] && !loaderBusy)) begin
      if (flashCtrl[FC_ERASE_BIT] && $onehot(eraseBlk)) next_eraseBlockEnable = eraseBlk; // (R7) (R8)
    end
    next_ovlHit = ovlCtrl[OVL_SEL_BIT] && (flashRdAddr[23:15] == 9'h000) &&
      (flashRdAddr[14:12] == ovlCtrl[2:0]); // (R9) (R10)
    next_ovlRamAddr = OVL_RAM_BASE | {12'h000, flashRdAddr[SMALL_BLOCK_SHIFT-1:0]}; // (R9)
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h00000000;
      flashCtrl <= FLASH_CTRL_RST;
      eraseBlk <= ERASE_BLK_RST;
      ovlCtrl <= OVERLAP_RST;
      programEnable <= 1'b0;
      eraseBlockEnable <= 12'h000;
      ovlHit <= 1'b0;
      ovlRamAddr <= 24'h000000;
    end else begin
      prdata <= next_prdata;
      flashCtrl <= next_flashCtrl;
      eraseBlk <= next_eraseBlk;
      ovlCtrl <= next_ovlCtrl;
      programEnable <= next_programEnable;
      eraseBlockEnable <= next_eraseBlockEnable;
      ovlHit <= next_ovlHit;
      ovlRamAddr <= next_ovlRamAddr;
    end
  end

  assign pready = psel && penable;
  assign pslverr = psel && penable && !mapped;
endmodule // flash_boot_mode_loader
`default_nettype wire

// [sim/flash_boot_mode_loader_props.sv]
`timescale 1ns/1ps
`default_nettype none
module flash_boot_mode_loader_props (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // apb handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // pins and flash side
  input wire logic modePinLow,
  input wire logic flashWriteEnablePin,
  input wire logic [23:0] flashRdAddr,
  input wire logic ovlHit,
  input wire logic [23:0] ovlRamAddr,
  input wire logic programEnable,
  input wire logic [flash_boot_pkg::NUM_BLOCKS-1:0] eraseBlockEnable,
  input wire logic eraseAllReq,
  // loader side
  input wire logic ramWrEn,
  input wire logic [23:0] ramWrAddr,
  input wire logic loaderAreaLock,
  input wire logic branchReq,
  input wire logic [23:0] branchAddr,
  input wire logic [1:0] opMode
);
  import flash_boot_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // sticky: whole erase was asked for
  logic eraseSeen, next_eraseSeen;
  always_comb next_eraseSeen = eraseSeen | eraseAllReq;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) eraseSeen <= 1'h0;
    else eraseSeen <= next_eraseSeen;
  end
  // named steps
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_lone_branch;
    branchReq ##1 !branchReq [*4];
  endsequence
  a_apb_zero_wait: assert property (s_access |-> pready)
    else $error("access cycle without ready");
  a_slverr_in_access: assert property (pslverr |-> s_access)
    else $error("slave error outside access");
  a_user_no_prog: assert property (opMode == OP_USER |-> !programEnable && eraseBlockEnable == '0)
    else $error("user mode may program");
  a_mode_from_pins: assert property (opMode != OP_USER |-> flashWriteEnablePin && modePinLow)
    else $error("programming mode with wrong pins");
  a_erase_one_block: assert property ($onehot0(eraseBlockEnable))
    else $error("more than one block erasable");
  a_ovl_ram_map: assert property (ovlHit |-> ovlRamAddr == (OVL_RAM_BASE | {12'h000, $past(flashRdAddr[11:0])}))
    else $error("overlap address wrong");
  a_ovl_small_blk: assert property (ovlHit |-> $past(flashRdAddr[23:15]) == 9'h000)
    else $error("overlap hit outside small blocks");
  a_branch_target: assert property (branchReq |-> branchAddr == BRANCH_ADDR && opMode == OP_BOOT)
    else $error("branch target or mode wrong");
  a_branch_pulse: assert property ($rose(branchReq) |-> s_lone_branch)
    else $error("branch not a lone pulse");
  a_erase_first: assert property (branchReq |-> eraseSeen)
    else $error("branch before whole erase");
  a_load_window: assert property (ramWrEn |-> opMode == OP_BOOT && loaderAreaLock && ramWrAddr >= BRANCH_ADDR)
    else $error("loader write outside boot area");
  a_erase_in_boot: assert property (eraseAllReq |-> loaderAreaLock && opMode == OP_BOOT)
    else $error("whole erase outside boot");
endmodule // flash_boot_mode_loader_props
bind flash_boot_mode_loader flash_boot_mode_loader_props u_props (.clk, .resetn, .psel, .penable, .pready,
  .pslverr, .modePinLow, .flashWriteEnablePin, .flashRdAddr, .ovlHit, .ovlRamAddr, .programEnable,
  .eraseBlockEnable, .eraseAllReq, .ramWrEn, .ramWrAddr, .loaderAreaLock, .branchReq, .branchAddr, .opMode);
`default_nettype wire

// [sim/host_serial_model.sv]
`timescale 1ns/1ps
`default_nettype none
module host_serial_model #(
  parameter int BIT_CYC = 1042
) (
  // clock
  input wire logic clk,
  // serial lines, pulled up when idle
  output logic hostTx,
  input wire logic hostRx
);
  // idle high
  initial hostTx = 1'h1;
  // 8N1 frame, lsb first
  task automatic send_byte(input logic [7:0] d);
    logic [9:0] f;
    f = {1'h1, d, 1'h0};
    for (int i = 0; i < 10; i++) begin
      hostTx <= f[i];
      repeat (BIT_CYC) @(posedge clk);
    end
  endtask
  // mid-bit sampling; silence ends at the watchdog
  task automatic recv_byte(output logic [7:0] d);
    @(negedge hostRx);
    @(posedge clk);
    repeat (BIT_CYC / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge clk);
      d[i] = hostRx;
    end
    repeat (BIT_CYC) @(posedge clk);
  endtask
endmodule // host_serial_model
`default_nettype wire

// [sim/flash_boot_mode_loader_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module flash_boot_mode_loader_tb_top;
  import flash_boot_pkg::*;
  logic clk, resetn, psel, penable, pwrite, pready, pslverr, slv;
  logic [7:0] paddr, ramWrData, lastData, b;
  logic [31:0] pwdata, prdata, rd;
  logic modePinHigh, modePinMid, modePinLow, flashWriteEnablePin, rxdPin, txdPin;
  logic [23:0] flashRdAddr, ovlRamAddr, ramWrAddr, branchAddr, lastAddr;
  logic ovlHit, programEnable, eraseAllReq, eraseAllDone, ramWrEn, loaderAreaLock, branchReq;
  logic [NUM_BLOCKS-1:0] eraseBlockEnable;
  logic [1:0] opMode;
  int errors, nTests, nWr, nBr;
  flash_boot_mode_loader u_dut (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .modePinHigh, .modePinMid, .modePinLow, .flashWriteEnablePin, .rxdPin, .txdPin, .flashRdAddr,
    .ovlHit, .ovlRamAddr, .programEnable, .eraseBlockEnable, .eraseAllReq, .eraseAllDone, .ramWrEn,
    .ramWrAddr, .ramWrData, .loaderAreaLock, .branchReq, .branchAddr, .opMode);
  host_serial_model u_host (.clk, .hostTx(rxdPin), .hostRx(txdPin));
  // 100 ns clock
  initial clk = 1'h0;
  always #50 clk = ~clk;
  // log loader writes and branch pulses
  always @(posedge clk) begin
    if (ramWrEn === 1'h1) begin
      nWr++;
      lastAddr = ramWrAddr;
      lastData = ramWrData;
    end
    if (branchReq === 1'h1) nBr++;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    nTests++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // held until ready is sampled; one idle edge after
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    q = prdata;
    slv = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d, rd);
    repeat (2) @(posedge clk);
  endtask
  task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'h0, a, 32'h0, rd);
    chk(n, e, rd & m);
  endtask
  // p is {write enable, high, mid, low}, set under reset
  task automatic boot_pins(input logic [3:0] p);
    resetn <= 1'h0;
    {flashWriteEnablePin, modePinHigh, modePinMid, modePinLow} <= p;
    repeat (12) @(posedge clk);
    resetn <= 1'h1;
    repeat (6) @(posedge clk);
    nWr = 0;
    nBr = 0;
  endtask
  task automatic t_modes();
    logic [23:0] pinTab;
    logic [41:0] expTab;
    pinTab = 24'h9bdfe7;
    expTab = {7'h6d, 7'h6f, 7'h75, 7'h77, 7'h46, 7'h07};
    for (int i = 0; i < 6; i++) begin
      boot_pins(pinTab[23-4*i -: 4]);
      rdchk("mode", OFS_MODE, {25'h0, expTab[41-7*i -: 7]}, 32'h7f);
      chk("opMode", expTab[39-7*i -: 2], opMode);
    end
  endtask
  task automatic t_user();
    boot_pins(4'he);
    wr(OFS_FLASH_CTRL, 32'h3);
    wr(OFS_ERASE_BLK, 32'h1);
    rdchk("ctrl", OFS_FLASH_CTRL, 32'h0, 32'h3);
    rdchk("blk", OFS_ERASE_BLK, 32'h0, 32'hfff);
    chk("progEn", 32'h0, programEnable);
  endtask
  task automatic t_uprog();
    boot_pins(4'hf);
    rdchk("ctrlRst", OFS_FLASH_CTRL, 32'h0, 32'hffffffff);
    rdchk("ovlRst", OFS_OVERLAP, 32'hf0, 32'hff);
    wr(OFS_MODE, 32'h0);
    rdchk("modeRo", OFS_MODE, 32'h77, 32'h7f);
    apb(1'h0, 8'h20, 32'h0, rd);
    chk("slverr", 32'h1, slv);
    chk("unmapped", 32'h0, rd);
    wr(OFS_FLASH_CTRL, 32'h3);
    chk("progEn", 32'h1, programEnable);
    for (int i = 0; i < NUM_BLOCKS; i++) begin
      wr(OFS_ERASE_BLK, 32'h1 << i);
      chk("eraseEn", 32'h1 << i, eraseBlockEnable);
    end
    wr(OFS_ERASE_BLK, 32'h3);
    chk("eraseTwo", 32'h0, eraseBlockEnable);
  endtask
  task automatic probe(input string n, input logic [23:0] a, input logic [31:0] e);
    flashRdAddr <= a;
    repeat (2) @(posedge clk);
    chk(n, e, ovlHit);
  endtask
  // user program mode, where emulation belongs
  task automatic t_overlap();
    wr(OFS_ERASE_BLK, 32'h8);
    wr(OFS_OVERLAP, 32'hb);
    chk("eraseOvl", 32'h0, eraseBlockEnable);
    probe("hit", 24'h003abc, 32'h1);
    chk("ramAddr", 32'hffeabc, ovlRamAddr);
    probe("otherBlk", 24'h002abc, 32'h0);
    wr(OFS_OVERLAP, 32'h3);
    probe("cancel", 24'h003abc, 32'h0);
    wr(OFS_FLASH_CTRL, 32'h0);
    repeat (20) @(posedge clk);
  endtask
  task automatic rate_up(input logic [3:0] p);
    boot_pins(p);
    chk("lock", 32'h1, loaderAreaLock);
    repeat (200) @(posedge clk);
    u_host.send_byte(8'h00);
    u_host.recv_byte(b);
    chk("ack", ACK_BYTE, b);
  endtask
  // rate, ack, confirm, length one, one byte
  task automatic t_boot();
    rate_up(4'h9);
    apb(1'h0, OFS_BOOT_STAT, 32'h0, rd);
    chk("period", 32'h1, rd[31:16] >= 16'd1041 && rd[31:16] <= 16'd1043);
    u_host.send_byte(CONFIRM_BYTE);
    u_host.send_byte(8'h00);
    u_host.send_byte(8'h01);
    u_host.send_byte(8'ha5);
    chk("nWr", 32'h1, nWr);
    chk("wrAddr", BRANCH_ADDR, lastAddr);
    chk("wrData", 32'ha5, lastData);
    for (int i = 0; i < 200 && eraseAllReq !== 1'h1; i++) @(posedge clk);
    chk("eraseReq", 32'h1, eraseAllReq);
    chk("earlyBr", 32'h0, nBr);
    eraseAllDone <= 1'h1;
    @(posedge clk);
    eraseAllDone <= 1'h0;
    for (int i = 0; i < 200 && nBr == 0; i++) @(posedge clk);
    repeat (2) @(posedge clk);
    chk("branch", 32'h1, nBr);
    chk("unlock", 32'h0, loaderAreaLock);
    rdchk("count", OFS_BOOT_COUNT, 32'h1, 32'hffff);
  endtask
  task automatic t_halt();
    rate_up(4'hb);
    u_host.send_byte(8'haa);
    repeat (20) @(posedge clk);
    rdchk("halt", OFS_BOOT_STAT, {28'h0, B_HALT}, 32'hf);
    chk("noLoad", 32'h0, nWr);
    chk("noErase", 32'h0, eraseAllReq);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", nTests, errors);
    if (errors == 0 && nTests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    {resetn, psel, penable, pwrite, eraseAllDone} = 5'h00;
    {paddr, pwdata, flashRdAddr} = 64'h0;
    {flashWriteEnablePin, modePinHigh, modePinMid, modePinLow} = 4'h0;
    @(posedge clk);
    t_modes();
    t_user();
    t_uprog();
    t_overlap();
    t_boot();
    t_halt();
    results();
  end
  // runs need about 94k cycles
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    results();
  end
endmodule // flash_boot_mode_loader_tb_top
`default_nettype wire
